// >>> pkg/eas_pkg.sv
/*
 * eas_pkg: constants, opcodes, states and carriers for the extended
 * arithmetic shift unit.
 * Assumes a 16-bit host with eight general registers and a 9-bit
 * microaddress whose bit 8 selects the option control store.
 */
package eas_pkg;

   // =========================================================================
   // instruction fields
   // =========================================================================
   localparam int          OP_HI        = 15;
   localparam int          OP_LO        = 9;
   localparam int          SF_HI        = 8;
   localparam int          SF_LO        = 6;
   localparam int          DM_HI        = 5;
   localparam int          DM_LO        = 3;
   localparam int          DR_HI        = 2;
   localparam int          DR_LO        = 0;
   localparam logic [6:0]  OP_SIGNED_MULTIPLY  = 7'h38; // octal 070
   localparam logic [6:0]  OP_DIVIDE           = 7'h39; // octal 071
   localparam logic [6:0]  OP_ARITH_SHIFT_WORD = 7'h3a; // octal 072
   localparam logic [6:0]  OP_ARITH_SHIFT_DBL  = 7'h3b; // octal 073

   // =========================================================================
   // addressing, exits and housekeeping values
   // =========================================================================
   localparam logic [2:0]  REG_PC       = 3'h7;
   localparam logic [15:0] WORD_STEP    = 16'h0002;
   localparam logic [8:0]  EXIT_UADDR   = 9'h00f;  // octal 17, service entry
   localparam logic [8:0]  TRAP_UADDR   = 9'h007;  // host trap entry
   localparam logic [7:0]  TRAP_VECTOR  = 8'h08;   // octal 10
   localparam logic [7:0]  CNT_RESET    = 8'h00;
   localparam logic [23:0] UWORD_NULL   = 24'h000000;
   localparam int          CNT_SIGN_BIT = 5;

   // =========================================================================
   // carriers
   // =========================================================================
   typedef struct packed {
      logic n;
      logic z;
      logic v;
      logic c;
   } eas_cc_s;

   typedef struct packed {
      logic        we;
      logic [2:0]  addr;
      logic [15:0] data;
   } eas_gr_wr_s;

   // one-hot sequencer states
   typedef enum logic [19:0] {
      ST_IDLE  = 20'h00001,
      ST_DEC   = 20'h00002,
      ST_PTR   = 20'h00004,
      ST_PCRD  = 20'h00008,
      ST_IDX   = 20'h00010,
      ST_IND   = 20'h00020,
      ST_OPT   = 20'h00040,
      ST_OPND  = 20'h00080,
      ST_SRCLO = 20'h00100,
      ST_SRCHI = 20'h00200,
      ST_STEP  = 20'h00400,
      ST_STHI  = 20'h00800,
      ST_STLO  = 20'h01000,
      ST_MUL   = 20'h02000,
      ST_MULHI = 20'h04000,
      ST_MULLO = 20'h08000,
      ST_PSW   = 20'h10000,
      ST_NULLW = 20'h20000,
      ST_EXIT  = 20'h40000,
      ST_TRAP  = 20'h80000
   } eas_state_e;

endpackage : eas_pkg

// >>> rtl/eas_unit.sv
/*
 * eas_unit: extended arithmetic shift unit. Fetches the destination
 * operand, runs the word and double-word arithmetic shifts and a signed
 * multiply, hands condition codes back and returns control to the host.
 * Assumes the host shows gr_rdata for gr_addr_q in the same cycle, answers
 * bus reads with bus_ack, and pulses opt_enter on the decode branch.
 */
// Behaviour
// - branch on destination mode 0 to 7
// - test opcode two words before path exit
// - operand copied to b-side, B, destination copy
// - word shift: signed count, source register rewritten
// - double: even high, register or 1 low
// - odd register: low result overwrites high
// - load low eight count bits, test 5:0
// - bit5 set right and count up, else left
// - right step: sign extends, low bit to carry
// - one position per pass, stop at zero
// - left step doubles, top bit into carry
// - overflow set on top bits differing, sticky
// - overflow cleared at shift start
// - zero count: no shift, flags from operand
// - negative from sign, zero from result
// - flags to status word, clear select bit
// - null word clears upper 24 bits
// - every exit except trap resumes host at octal 17
// - double zero test ORs both halves
// - double right: high lsb into low msb
// - double left: zero into low bit 0
// - multiply: product high to source, low odd
// - select bit set when host pulses decode branch
// - reserved instruction: vector 10, trap exit
`timescale 1ns/100ps
`default_nettype none
module eas_unit
   import eas_pkg::*;
(
   input  wire logic        clk_sys,         // 25 MHz system clock
   input  wire logic        sys_rst,         // async reset, active high
   input  wire logic        opt_enter,       // pulse: host took decode branch
   input  wire logic [15:0] instr,           // instruction register
   input  wire logic [15:0] gr_rdata,        // register at gr_addr_q
   input  wire logic        bus_ack,         // pulse: read data valid
   input  wire logic [15:0] bus_rdata,       // bus read data
   output logic [2:0]       gr_addr_q,       // register read select
   output eas_gr_wr_s       gr_wr_q,         // register write, one cycle
   output logic             bus_rd_q,        // bus read request, level
   output logic [15:0]      bus_addr_q,      // bus read address
   output logic             option_store_select_bit_q, // microaddress bit 8
   output logic [23:0]      uword_hi_q,      // upper microword bits
   output eas_cc_s          psw_cc_q,        // status word condition codes
   output logic             psw_we_q,        // pulse: load psw_cc_q
   output logic             exit_q,          // pulse: resume host
   output logic [8:0]       exit_uaddr_q,    // host resume address
   output logic [7:0]       trap_vec_q,      // trap vector on reserved op
   output logic [15:0]      operand_b_q,     // B copy of operand
   output logic [15:0]      destination_copy_reg_q // destination copy
);

   // ========================================================================
   // decode
   // ========================================================================
   function automatic logic is_shift(input logic [6:0] op);
      is_shift = (op == OP_ARITH_SHIFT_WORD) || (op == OP_ARITH_SHIFT_DBL);
   endfunction : is_shift

   eas_state_e  state_q;
   logic [15:0] instr_q;
   logic [15:0] ea_q;
   logic [15:0] work_reg_b_side_q;   // high half / count source
   logic [15:0] low_half_shift_reg_q;
   logic [7:0]  cnt_q;
   logic        right_q;
   eas_cc_s     cc_q;               // local flags

   // instruction fields
   wire logic [6:0]  op         = instr_q[OP_HI:OP_LO];
   wire logic [2:0]  src_reg    = instr_q[SF_HI:SF_LO];
   wire logic [2:0]  src_odd    = instr_q[SF_HI:SF_LO] | 3'h1;
   wire logic [2:0]  dmode      = instr_q[DM_HI:DM_LO];
   wire logic [2:0]  dreg       = instr_q[DR_HI:DR_LO];
   wire logic        is_double  = (op == OP_ARITH_SHIFT_DBL);
   wire logic        register_direct_mode = (dmode == 3'h0);

   // operand source: register in mode 0, bus read data otherwise
   wire logic [15:0] opnd_val   = register_direct_mode ? gr_rdata : bus_rdata;
   wire logic        opnd_rdy   = register_direct_mode || bus_ack;
   wire logic [15:0] gr_inc     = gr_rdata + WORD_STEP;
   wire logic [15:0] gr_dec     = gr_rdata - WORD_STEP;
   wire logic [15:0] idx_ea     = ea_q + bus_rdata;

   // ========================================================================
   // shift step datapath
   // ========================================================================
   wire logic [15:0] hi         = work_reg_b_side_q;
   wire logic [15:0] lo         = low_half_shift_reg_q;
   wire logic [15:0] r_hi       = {hi[15], hi[15:1]};
   wire logic [15:0] r_lo       = {hi[0], lo[15:1]};
   wire logic        r_c        = is_double ? lo[0] : hi[0];
   wire logic [15:0] l_hi       = hi + hi + {15'h0000, is_double & lo[15]};
   wire logic [15:0] l_lo       = {lo[14:0], 1'b0};
   wire logic        l_v        = cc_q.v | (hi[15] ^ hi[14]);
   // six-bit two's complement count: right counts up toward zero
   wire logic [7:0]  cnt_next   = right_q ? cnt_q + 8'h01 : cnt_q - 8'h01;
   wire logic        cnt_done   = (cnt_next[CNT_SIGN_BIT:0] == 6'h00);
   wire logic [5:0]  cnt_field  = work_reg_b_side_q[CNT_SIGN_BIT:0];
   wire logic        res_zero   = ((hi | (is_double ? lo : 16'h0000)) == 16'h0000);

   // ========================================================================
   // multiply
   // ========================================================================
   wire logic signed [31:0] product = $signed(destination_copy_reg_q) * $signed(gr_rdata);
   wire logic        prod_wide  = (product[31:16] != {16{product[15]}});

   // ========================================================================
   // sequencer and datapath
   // ========================================================================
   // pulses default low each cycle; everything else holds
   always_ff @(posedge clk_sys or posedge sys_rst) begin
      if (sys_rst) begin
         state_q                   <= ST_IDLE;
         instr_q                   <= 16'h0000;
         ea_q                      <= 16'h0000;
         work_reg_b_side_q         <= 16'h0000;
         low_half_shift_reg_q      <= 16'h0000;
         operand_b_q               <= 16'h0000;
         destination_copy_reg_q    <= 16'h0000;
         cnt_q                     <= CNT_RESET;
         right_q                   <= 1'b0;
         cc_q                      <= '0;
         gr_addr_q                 <= 3'h0;
         gr_wr_q                   <= '0;
         bus_rd_q                  <= 1'b0;
         bus_addr_q                <= 16'h0000;
         option_store_select_bit_q <= 1'b0;
         uword_hi_q                <= UWORD_NULL;
         psw_cc_q                  <= '0;
         psw_we_q                  <= 1'b0;
         exit_q                    <= 1'b0;
         exit_uaddr_q              <= EXIT_UADDR;
         trap_vec_q                <= 8'h00;
      end else begin
         gr_wr_q.we <= 1'b0;
         psw_we_q   <= 1'b0;
         exit_q     <= 1'b0;
         case (state_q)
            ST_IDLE: begin
               if (opt_enter) begin
                  option_store_select_bit_q <= 1'b1;
                  instr_q    <= instr;
                  uword_hi_q <= {8'h00, instr};
                  state_q    <= ST_DEC;
               end
            end
            ST_DEC: begin
               gr_addr_q <= dreg;
               if (!(is_shift(op) || op == OP_SIGNED_MULTIPLY)) begin
                  state_q <= ST_TRAP;
               end else if (register_direct_mode) begin
                  state_q <= ST_OPT;
               end else begin
                  state_q <= ST_PTR;
               end
            end
            ST_PTR: begin
               // modes 1..7 differ only in pointer update, indexing and deferral
               gr_wr_q.addr <= dreg;
               ea_q         <= (dmode == 3'h4 || dmode == 3'h5) ? gr_dec : gr_rdata;
               bus_addr_q   <= (dmode == 3'h5) ? gr_dec : gr_rdata;
               case (dmode)
                  3'h1: state_q <= ST_OPT;
                  3'h2: begin
                     gr_wr_q <= '{we: 1'b1, addr: dreg, data: gr_inc};
                     state_q <= ST_OPT;
                  end
                  3'h3: begin
                     gr_wr_q  <= '{we: 1'b1, addr: dreg, data: gr_inc};
                     bus_rd_q <= 1'b1;
                     state_q  <= ST_IND;
                  end
                  3'h4: begin
                     gr_wr_q <= '{we: 1'b1, addr: dreg, data: gr_dec};
                     state_q <= ST_OPT;
                  end
                  3'h5: begin
                     gr_wr_q  <= '{we: 1'b1, addr: dreg, data: gr_dec};
                     bus_rd_q <= 1'b1;
                     state_q  <= ST_IND;
                  end
                  default: begin
                     gr_addr_q <= REG_PC;
                     state_q   <= ST_PCRD;
                  end
               endcase
            end
            ST_PCRD: begin
               // index word follows the instruction
               gr_wr_q    <= '{we: 1'b1, addr: REG_PC, data: gr_inc};
               bus_addr_q <= gr_rdata;
               bus_rd_q   <= 1'b1;
               state_q    <= ST_IDX;
            end
            ST_IDX: begin
               if (bus_ack) begin
                  ea_q       <= idx_ea;
                  bus_addr_q <= idx_ea;
                  bus_rd_q   <= (dmode == 3'h7);
                  state_q    <= (dmode == 3'h7) ? ST_IND : ST_OPT;
               end
            end
            ST_IND: begin
               if (bus_ack) begin
                  ea_q     <= bus_rdata;
                  bus_rd_q <= 1'b0;
                  state_q  <= ST_OPT;
               end
            end
            ST_OPT: begin
               // opcode test, two words ahead of the path exit
               bus_addr_q <= ea_q;
               bus_rd_q   <= !register_direct_mode;
               right_q    <= 1'b0;
               state_q    <= ST_OPND;
            end
            ST_OPND: begin
               if (opnd_rdy) begin
                  bus_rd_q               <= 1'b0;
                  work_reg_b_side_q      <= opnd_val;
                  operand_b_q            <= opnd_val;
                  destination_copy_reg_q <= opnd_val;
                  low_half_shift_reg_q   <= 16'h0000;
                  gr_addr_q              <= is_double ? src_odd : src_reg;
                  if (op == OP_SIGNED_MULTIPLY) begin
                     state_q <= ST_MUL;
                  end else if (is_double) begin
                     state_q <= ST_SRCLO;
                  end else begin
                     state_q <= ST_SRCHI;
                  end
               end
            end
            ST_SRCLO: begin
               low_half_shift_reg_q <= gr_rdata;
               gr_addr_q            <= src_reg;
               state_q              <= ST_SRCHI;
            end
            ST_SRCHI: begin
               cnt_q             <= work_reg_b_side_q[7:0];
               right_q           <= work_reg_b_side_q[CNT_SIGN_BIT];
               work_reg_b_side_q <= gr_rdata;
               operand_b_q       <= gr_rdata;
               cc_q.v            <= 1'b0;
               cc_q.c            <= 1'b0;
               state_q           <= (cnt_field == 6'h00) ? ST_STHI : ST_STEP;
            end
            ST_STEP: begin
               cnt_q <= cnt_next;
               if (right_q) begin
                  work_reg_b_side_q    <= r_hi;
                  operand_b_q          <= r_hi;
                  low_half_shift_reg_q <= is_double ? r_lo : lo;
                  cc_q.c               <= r_c;
               end else begin
                  work_reg_b_side_q    <= l_hi;
                  operand_b_q          <= l_hi;
                  low_half_shift_reg_q <= is_double ? l_lo : lo;
                  cc_q.c               <= hi[15];
                  cc_q.v               <= l_v;
               end
               if (cnt_done) begin
                  state_q <= ST_STHI;
               end
            end
            ST_STHI: begin
               gr_wr_q <= '{we: 1'b1, addr: src_reg, data: hi};
               cc_q.n  <= hi[15];
               cc_q.z  <= res_zero;
               state_q <= is_double ? ST_STLO : ST_PSW;
            end
            ST_STLO: begin
               // odd source: same register, low overwrites high
               gr_wr_q <= '{we: 1'b1, addr: src_odd, data: lo};
               state_q <= ST_PSW;
            end
            ST_MUL: begin
               work_reg_b_side_q    <= product[31:16];
               low_half_shift_reg_q <= product[15:0];
               cc_q <= '{n: product[31], z: (product == 32'sh0), v: 1'b0, c: prod_wide};
               state_q <= ST_MULHI;
            end
            ST_MULHI: begin
               gr_wr_q <= '{we: 1'b1, addr: src_reg, data: hi};
               state_q <= ST_MULLO;
            end
            ST_MULLO: begin
               gr_wr_q <= '{we: 1'b1, addr: src_odd, data: lo};
               state_q <= ST_PSW;
            end
            ST_PSW: begin
               psw_cc_q                  <= cc_q;
               psw_we_q                  <= 1'b1;
               option_store_select_bit_q <= 1'b0;
               state_q                   <= ST_NULLW;
            end
            ST_NULLW: begin
               uword_hi_q <= UWORD_NULL;
               state_q    <= ST_EXIT;
            end
            ST_EXIT: begin
               exit_q       <= 1'b1;
               exit_uaddr_q <= EXIT_UADDR;
               state_q      <= ST_IDLE;
            end
            ST_TRAP: begin
               trap_vec_q                <= TRAP_VECTOR;
               option_store_select_bit_q <= 1'b0;
               uword_hi_q                <= UWORD_NULL;
               exit_q                    <= 1'b1;
               exit_uaddr_q              <= TRAP_UADDR;
               state_q                   <= ST_IDLE;
            end
            default: state_q <= ST_IDLE;
         endcase
      end
   end

   // ========================================================================
   // checks
   // ========================================================================
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (sys_rst);

   sequence s_psw_done;
      psw_we_q && !option_store_select_bit_q;
   endsequence
   sequence s_null_exit;
      uword_hi_q == UWORD_NULL ##1 exit_q && exit_uaddr_q == EXIT_UADDR;
   endsequence

   exit_after_psw_a: assert property (s_psw_done |=> s_null_exit)
      else $error("status load not followed by null word and exit");
   ovf_clear_start_a: assert property (state_q == ST_SRCHI |=> !cc_q.v)
      else $error("overflow not cleared at shift start");
   ovf_sticky_a: assert property (state_q == ST_STEP && cc_q.v |=> cc_q.v)
      else $error("overflow dropped during shift");
   right_carry_a: assert property (state_q == ST_STEP && right_q && !is_double
         |=> cc_q.c == $past(work_reg_b_side_q[0]) && work_reg_b_side_q[15] == $past(hi[15]))
      else $error("right step carry or sign wrong");
   left_carry_a: assert property (state_q == ST_STEP && !right_q
         |=> cc_q.c == $past(hi[15]) && work_reg_b_side_q[0] == (is_double & $past(lo[15])))
      else $error("left step carry or fill wrong");
   no_shift_a: assert property (state_q == ST_SRCHI && cnt_field == 6'h00
         |=> state_q == ST_STHI && !cc_q.v && !cc_q.c)
      else $error("zero count did not skip shifting");
   count_dir_a: assert property (state_q == ST_STEP
         |=> cnt_q == ($past(right_q) ? $past(cnt_q) + 8'h01 : $past(cnt_q) - 8'h01))
      else $error("count stepped the wrong way");
   trap_exit_a: assert property (state_q == ST_TRAP
         |=> exit_q && trap_vec_q == TRAP_VECTOR && !option_store_select_bit_q)
      else $error("reserved opcode did not trap");
   zero_flag_a: assert property (state_q == ST_STHI |=> cc_q.z == $past(res_zero))
      else $error("zero flag wrong");
   dbl_store_a: assert property (state_q == ST_STHI && is_double
         |=> gr_wr_q.we && gr_wr_q.addr == src_reg ##1 gr_wr_q.we && gr_wr_q.addr == src_odd)
      else $error("double halves not stored high then low");

endmodule : eas_unit
`default_nettype wire

// >>> verif/eas_host_model.sv
/*
 * eas_host_model: host side of the shift unit, i.e. register file and bus.
 * Assumes one clock; the testbench preloads regs and mem directly.
 */
`timescale 1ns/100ps
`default_nettype none
module eas_host_model
   import eas_pkg::*;
#(
   parameter int ACK_DLY = 2
)
(
   input  wire logic        clk_sys,   // system clock
   input  wire logic [2:0]  gr_addr,   // register select
   input  wire eas_gr_wr_s  gr_wr,     // register write
   input  wire logic        bus_rd,    // read request
   input  wire logic [15:0] bus_addr,  // read address
   output logic [15:0]      gr_rdata,  // register value
   output logic             bus_ack,   // read answer
   output logic [15:0]      bus_rdata  // read data
);
   logic [15:0] regs [8];
   logic [15:0] mem  [8];
   logic [15:0] last     = 16'h0000;
   int          wait_cnt = 0;
   logic        ack_q    = 1'b0;
   // =========================================================================
   // register file and slow bus
   // =========================================================================
   assign gr_rdata  = regs[gr_addr];
   // idle data is the inverse of the last word, so stale sampling shows up
   assign bus_rdata = ack_q ? mem[bus_addr[3:1]] : ~last;
   assign bus_ack   = ack_q;
   // answer after ACK_DLY waits, one pulse per request
   always @(posedge clk_sys) begin
      if (gr_wr.we) regs[gr_wr.addr] <= gr_wr.data;
      if (ack_q) last <= bus_rdata;
      ack_q    <= bus_rd && !ack_q && wait_cnt == ACK_DLY;
      wait_cnt <= (bus_rd && !ack_q) ? wait_cnt + 1 : 0;
   end
endmodule : eas_host_model
`default_nettype wire

// >>> verif/testbench.sv
/*
 * testbench: runs word, double and multiply operations and a trap.
 * Assumes eas_unit and eas_host_model; inputs change on falling edges.
 */
`timescale 1ns/100ps
`default_nettype none
module testbench;
   import eas_pkg::*;
   logic clk_sys = 1'b0, sys_rst = 1'b1, opt_enter = 1'b0;
   logic bus_ack, bus_rd_q, sel_q, exit_q, psw_we_q;
   logic [15:0] instr = 16'h0000, gr_rdata, bus_rdata, bus_addr_q, op_b, dcopy;
   logic [2:0] gr_addr_q;
   logic [23:0] uword_hi_q;
   logic [8:0] exit_uaddr_q;
   logic [7:0] trap_vec_q;
   eas_gr_wr_s gr_wr_q;
   eas_cc_s psw_cc_q;
   int bad_count = 0, comparisons = 0;
   always #20 clk_sys = ~clk_sys;
   eas_unit u_dut (.clk_sys(clk_sys), .sys_rst(sys_rst), .opt_enter(opt_enter), .instr(instr),
      .gr_rdata(gr_rdata), .bus_ack(bus_ack), .bus_rdata(bus_rdata), .gr_addr_q(gr_addr_q),
      .gr_wr_q(gr_wr_q), .bus_rd_q(bus_rd_q), .bus_addr_q(bus_addr_q),
      .option_store_select_bit_q(sel_q), .uword_hi_q(uword_hi_q), .psw_cc_q(psw_cc_q),
      .psw_we_q(psw_we_q), .exit_q(exit_q), .exit_uaddr_q(exit_uaddr_q),
      .trap_vec_q(trap_vec_q), .operand_b_q(op_b), .destination_copy_reg_q(dcopy));
   eas_host_model u_host (.clk_sys(clk_sys), .gr_addr(gr_addr_q), .gr_wr(gr_wr_q),
      .bus_rd(bus_rd_q), .bus_addr(bus_addr_q), .gr_rdata(gr_rdata), .bus_ack(bus_ack),
      .bus_rdata(bus_rdata));
   // =========================================================================
   // checking and operation tasks
   // =========================================================================
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      comparisons++;
      if (seen !== exp) begin
         bad_count++;
         $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask : chk
   task automatic end_sim;
      $display("comparisons %0d mismatches %0d", comparisons, bad_count);
      if (bad_count == 0 && comparisons > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask : end_sim
   // one operation: pulse the decode branch, wait bounded for the exit pulse
   task automatic run(input logic [15:0] iw, input logic [8:0] ua);
      int   n;
      logic we_seen;
      @(negedge clk_sys);
      instr     = iw;
      opt_enter = 1'b1;
      @(negedge clk_sys);
      opt_enter = 1'b0;
      chk(sel_q, 1'b1);
      n = 0;
      we_seen = 1'b0;
      while (exit_q !== 1'b1 && n < 300) begin
         @(negedge clk_sys);
         n++;
         we_seen = we_seen | psw_we_q;
      end
      chk({exit_q, exit_uaddr_q}, {1'b1, ua});
      chk(we_seen, ua == EXIT_UADDR);
      chk(sel_q, 1'b0);
      chk(uword_hi_q, UWORD_NULL);
   endtask : run
   // shift r0 (3) left by a count of 1 fetched through mode dm, pointer in r1
   task automatic mode_run(input logic [2:0] dm, input logic [15:0] p, input logic [15:0] p_exp);
      u_host.regs[0] = 16'h0003;
      u_host.regs[1] = p;
      u_host.regs[7] = 16'h000c;
      run({OP_ARITH_SHIFT_WORD, 3'd0, dm, 3'd1}, EXIT_UADDR);
      chk({u_host.regs[0], u_host.regs[1]}, {16'h0006, p_exp});
      chk(u_host.regs[7], (dm[2] && dm[1]) ? 16'h000e : 16'h000c);
      chk(dcopy, 16'h0001);
   endtask : mode_run
   // watchdog, far beyond the few hundred cycles the sequence needs
   initial begin
      #200us;
      bad_count++;
      end_sim();
   end
   initial begin
      repeat (12) @(negedge clk_sys);
      sys_rst = 1'b0;
      u_host.regs[0] = 16'h4001; u_host.regs[1] = 16'h0002;
      run({OP_ARITH_SHIFT_WORD, 3'd0, 3'd0, 3'd1}, EXIT_UADDR);
      chk(u_host.regs[0], 16'h0004);
      chk(psw_cc_q, 4'h3);
      u_host.regs[2] = 16'h8005; u_host.regs[3] = 16'h003d;
      run({OP_ARITH_SHIFT_WORD, 3'd2, 3'd0, 3'd3}, EXIT_UADDR);
      chk(u_host.regs[2], 16'hf000);
      chk(psw_cc_q, 4'h9);
      u_host.regs[4] = 16'h8000; u_host.regs[5] = 16'h0040;
      run({OP_ARITH_SHIFT_WORD, 3'd4, 3'd0, 3'd5}, EXIT_UADDR);
      chk({u_host.regs[4], psw_cc_q}, {16'h8000, 4'h8});
      u_host.regs[2] = 16'h0001; u_host.regs[3] = 16'h0000; u_host.regs[6] = 16'h003f;
      run({OP_ARITH_SHIFT_DBL, 3'd2, 3'd0, 3'd6}, EXIT_UADDR);
      chk({u_host.regs[2], u_host.regs[3]}, 32'h00008000);
      chk(psw_cc_q, 4'h0);
      u_host.regs[4] = 16'h0000; u_host.regs[5] = 16'h8001; u_host.regs[6] = 16'h0001;
      run({OP_ARITH_SHIFT_DBL, 3'd4, 3'd0, 3'd6}, EXIT_UADDR);
      chk({u_host.regs[4], u_host.regs[5]}, 32'h00010002);
      u_host.regs[5] = 16'h4000;
      run({OP_ARITH_SHIFT_DBL, 3'd5, 3'd0, 3'd6}, EXIT_UADDR);
      chk(u_host.regs[5], 16'h8000);
      chk(psw_cc_q, 4'ha);
      u_host.regs[0] = 16'hfffe; u_host.regs[1] = 16'h0003;
      run({OP_SIGNED_MULTIPLY, 3'd0, 3'd0, 3'd1}, EXIT_UADDR);
      chk({u_host.regs[0], u_host.regs[1]}, 32'hfffffffa);
      chk(psw_cc_q, 4'h8);
      u_host.regs[0] = 16'h0003; u_host.regs[1] = 16'h0004; u_host.mem[2] = 16'h0001;
      run({OP_ARITH_SHIFT_WORD, 3'd0, 3'd1, 3'd1}, EXIT_UADDR);
      chk({u_host.regs[0], u_host.regs[1]}, 32'h00060004);
      chk({dcopy, op_b}, 32'h00010006);
      u_host.mem[4] = 16'h0004;
      u_host.mem[6] = 16'h0004;
      mode_run(3'd2, 16'h0004, 16'h0006);
      mode_run(3'd3, 16'h0008, 16'h000a);
      mode_run(3'd4, 16'h0006, 16'h0004);
      mode_run(3'd5, 16'h000a, 16'h0008);
      mode_run(3'd6, 16'h0000, 16'h0000);
      mode_run(3'd7, 16'h0004, 16'h0004);
      run({OP_DIVIDE, 9'h000}, TRAP_UADDR);
      chk(trap_vec_q, TRAP_VECTOR);
      end_sim();
   end
endmodule : testbench
`default_nettype wire
